// >>> uam_uart.sv
// Purpose: Asynchronous serial port, 10-bit and 11-bit frame modes.
// Assumes: Timer overflow pulses are one sys_clk wide and on sys_clk.
// Notes: Shift mode (mode 0) is not handled; both directions stay idle in it.
//
// Functional notes
// [RQ1] 10-bit frame: start 0, eight data bits LSB first, stop 1.
// [RQ2] 10-bit mode: accepted stop bit goes into receive ninth-bit flag.
// [RQ3] 10-bit mode: rate from timer 1 or timer 2, separately per direction.
// [RQ4] 10-bit mode: data write loads 1 into ninth shift position, requests transmit.
// [RQ5] Transmit starts at next divide-by-16 rollover, not at the write.
// [RQ6] Start bit drives pin; one bit later data; first shift one bit after.
// [RQ7] 10-bit mode: marker left of MSB triggers last shift, done at tenth rollover.
// [RQ8] Receive pin sampled at 16x; falling edge resets counter, loads 1FFH.
// [RQ9] Each bit sampled at counter states 7, 8, 9; majority wins.
// [RQ10] First bit not 0: receiver resets and hunts again.
// [RQ11] 9-bit receive shift register; start at end triggers final shift and load.
// [RQ12] 10-bit mode: store only if receive-done clear and (no multiproc or stop 1).
// [RQ13] 10-bit mode: hunt resumes right after final shift.
// [RQ14] 11-bit frame: start 0, eight data LSB first, ninth bit, stop 1.
// [RQ15] Fixed 11-bit mode: rate is clock/16 or clock/32, software chosen.
// [RQ16] Variable 11-bit mode: timer 1 or 2 per clock-select bits.
// [RQ17] 11-bit modes: data write loads transmit ninth-bit value, requests transmit.
// [RQ18] 11-bit modes: first shift inserts stop 1, later shifts insert zeros.
// [RQ19] 11-bit modes: ninth bit at output triggers last shift, done at 11th rollover.
// [RQ20] 11-bit modes: accept if receive-done clear and (no multiproc or ninth 1).
// [RQ21] 11-bit modes: hunt resumes one bit later; rejected frame leaves done clear.
// [RQ22] 11-bit modes: received stop bit affects nothing.
// [RQ23] Independent 16x ticks for receive and transmit from selected source.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps

module uam_uart (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire uam_pkg::uam_bus_req_t bus_req,
   output logic [7:0] rd_data,
   // Baud sources
   input wire logic timer1_ovf,
   input wire logic timer2_ovf,
   // Serial pins
   input wire logic rxd,
   output logic txd
);
   import uam_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   uam_ctrl_t ctrl;
   logic tx_done_flag;
   logic rx_done_flag;
   logic rx_ninth_bit_flag;
   logic [7:0] serial_data_buffer;
   logic osc_half;
   logic tx_tick;
   logic rx_tick;
   logic [3:0] tx_div;
   logic tx_roll;
   logic tx_req;
   logic tx_first;
   logic [8:0] tx_sr;
   logic [8:0] next_tx_sr;
   logic tx_finish;
   logic data_wr;
   logic data_wr_ok;
   logic mode_on;
   uam_tx_state_t tx_state;
   logic rx_sync1;
   logic rx_sync2;
   logic rx_last;
   logic rx_fall;
   logic [3:0] rx_div;
   logic [1:0] rx_smp;
   logic rx_mid;
   logic rx_bit;
   logic rx_first;
   logic [8:0] rx_sr;
   logic rx_final;
   logic rx_accept;
   uam_rx_state_t rx_state;
   logic clr_wr;
   logic [7:0] status_word;

   assign mode_on = (ctrl.mode != MODE_SHIFT);
   assign data_wr = bus_req.wr && (bus_req.addr == REG_DATA);
   // A write while a frame is pending or on the line is dropped
   assign data_wr_ok = data_wr && mode_on && !tx_req && (tx_state == TX_IDLE);
   assign clr_wr = bus_req.wr && (bus_req.addr == REG_STATUS);
   assign status_word = {4'h0, (tx_req || (tx_state != TX_IDLE)), rx_ninth_bit_flag,
                         tx_done_flag, rx_done_flag};

   // ************************************************************
   // Baud ticks
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         osc_half <= 1'h0;
      end else begin
         osc_half <= ~osc_half;
      end
   end

   always_comb begin
      if (ctrl.mode == MODE_11_FIXED) begin
         tx_tick = ctrl.rate_div32 ? osc_half : 1'h1; // RQ15
         rx_tick = ctrl.rate_div32 ? osc_half : 1'h1; // RQ15
      end else begin
         tx_tick = ctrl.tx_clock_select ? timer2_ovf : timer1_ovf; // RQ3 RQ16 RQ23
         rx_tick = ctrl.rx_clock_select ? timer2_ovf : timer1_ovf; // RQ3 RQ16 RQ23
      end
   end

   // ************************************************************
   // Register port
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl <= uam_ctrl_t'(CTRL_RESET);
      end else if (bus_req.wr && (bus_req.addr == REG_CTRL)) begin
         ctrl <= uam_ctrl_t'(bus_req.wdata);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            REG_CTRL: rd_data <= ctrl;
            REG_STATUS: rd_data <= status_word;
            REG_DATA: rd_data <= serial_data_buffer;
            default: rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ************************************************************
   // Transmitter
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_div <= 4'h0;
      end else if (tx_tick) begin
         tx_div <= tx_div + 4'h1;
      end
   end

   assign tx_roll = tx_tick && (tx_div == DIV_LAST);
   // Stop bit enters only on the first shift of an 11-bit frame
   assign next_tx_sr = uam_shift9(tx_sr, tx_first && (ctrl.mode != MODE_10BIT)); // RQ18
   // The first-shift guard keeps an unshifted pattern from ending early
   assign tx_finish = tx_roll && (tx_state == TX_DATA) && !tx_first &&
                      (tx_sr[8:1] == TX_END_PATTERN); // RQ7 RQ19

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_state <= TX_IDLE;
         tx_sr <= 9'h000;
         tx_req <= 1'h0;
         tx_first <= 1'h0;
         txd <= 1'h1;
      end else begin
         if (data_wr_ok) begin
            if (ctrl.mode == MODE_10BIT) begin
               tx_sr <= {1'h1, bus_req.wdata}; // RQ4
            end else begin
               tx_sr <= {ctrl.tx_ninth_bit_value, bus_req.wdata}; // RQ17
            end
            tx_req <= 1'h1; // RQ4 RQ17
         end
         if (tx_roll) begin
            unique case (tx_state)
               TX_IDLE: begin
                  if (tx_req) begin
                     tx_state <= TX_START; // RQ5
                     tx_req <= 1'h0;
                     txd <= 1'h0; // RQ6 RQ1 RQ14
                  end
               end
               TX_START: begin
                  tx_state <= TX_DATA;
                  tx_first <= 1'h1;
                  txd <= tx_sr[0]; // RQ6
               end
               TX_DATA: begin
                  tx_sr <= next_tx_sr; // RQ6
                  tx_first <= 1'h0;
                  if (tx_finish) begin
                     tx_state <= TX_IDLE; // RQ7 RQ19
                     txd <= 1'h1;
                  end else begin
                     txd <= next_tx_sr[0];
                  end
               end
               default: begin
                  tx_state <= TX_IDLE;
                  txd <= 1'h1;
               end
            endcase
         end
      end
   end

   // Set wins over a same-cycle software clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_done_flag <= 1'h0;
      end else if (tx_finish) begin
         tx_done_flag <= 1'h1; // RQ7 RQ19
      end else if (clr_wr && bus_req.wdata[ST_TX_DONE]) begin
         tx_done_flag <= 1'h0;
      end
   end

   // ************************************************************
   // Receiver
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_sync1 <= 1'h1;
         rx_sync2 <= 1'h1;
      end else begin
         rx_sync1 <= rxd;
         rx_sync2 <= rx_sync1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_last <= 1'h1;
      end else if (rx_tick) begin
         rx_last <= rx_sync2; // RQ8
      end
   end

   assign rx_fall = rx_tick && rx_last && !rx_sync2; // RQ8
   assign rx_mid = rx_tick && (rx_div == SAMPLE3);
   assign rx_bit = uam_vote(rx_smp[0], rx_smp[1], rx_sync2); // RQ9
   assign rx_final = rx_mid && (rx_state == RX_BITS) && !rx_first && !rx_sr[0]; // RQ11
   assign rx_accept = rx_final && !rx_done_flag &&
                      (!ctrl.multiproc_enable || rx_bit); // RQ12 RQ20

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_div <= 4'h0;
         rx_smp <= 2'h0;
      end else if (rx_state == RX_HUNT && rx_fall) begin
         rx_div <= 4'h0; // RQ8
      end else if (rx_tick) begin
         rx_div <= rx_div + 4'h1;
         if (rx_div == SAMPLE1) begin
            rx_smp[0] <= rx_sync2; // RQ9
         end
         if (rx_div == SAMPLE2) begin
            rx_smp[1] <= rx_sync2; // RQ9
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_state <= RX_HUNT;
         rx_sr <= RX_SR_INIT;
         rx_first <= 1'h0;
      end else begin
         unique case (rx_state)
            RX_HUNT: begin
               if (rx_fall && ctrl.rx_enable && mode_on) begin
                  rx_state <= RX_BITS;
                  rx_sr <= RX_SR_INIT; // RQ8
                  rx_first <= 1'h1;
               end
            end
            RX_BITS: begin
               if (rx_mid) begin
                  if (rx_first) begin
                     if (rx_bit) begin
                        rx_state <= RX_HUNT; // RQ10
                     end else begin
                        rx_sr <= uam_shift9(rx_sr, 1'h0); // RQ10
                        rx_first <= 1'h0;
                     end
                  end else begin
                     rx_sr <= uam_shift9(rx_sr, rx_bit); // RQ11
                     if (rx_final) begin
                        // 11-bit frames sit out the stop bit before hunting
                        if (ctrl.mode == MODE_10BIT) begin
                           rx_state <= RX_HUNT; // RQ13
                        end else begin
                           rx_state <= RX_TAIL; // RQ21
                        end
                     end
                  end
               end
            end
            RX_TAIL: begin
               if (rx_mid) begin
                  rx_state <= RX_HUNT; // RQ21 RQ22
               end
            end
            default: rx_state <= RX_HUNT;
         endcase
      end
   end

   // Frame landing beats a same-cycle software clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_done_flag <= 1'h0;
      end else if (rx_accept) begin
         rx_done_flag <= 1'h1; // RQ12 RQ20
      end else if (clr_wr && bus_req.wdata[ST_RX_DONE]) begin
         rx_done_flag <= 1'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serial_data_buffer <= 8'h00;
         rx_ninth_bit_flag <= 1'h0;
      end else if (rx_accept) begin
         serial_data_buffer <= rx_sr[8:1]; // RQ11 RQ20
         rx_ninth_bit_flag <= rx_bit; // RQ2 RQ20
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking chk_cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   chk_tx_start_low: assert property ((tx_state == TX_START) |-> !txd) // RQ6
      else $error("start bit not low on pin");
   chk_tx_idle_high: assert property ((tx_state == TX_IDLE) |-> txd) // RQ1
      else $error("idle line not high");
   chk_tx_load_marker: assert property ( // RQ4
      data_wr_ok && (ctrl.mode == MODE_10BIT) |=> tx_sr[8] && tx_req)
      else $error("marker not loaded on data write");
   chk_tx_load_ninth: assert property ( // RQ17
      data_wr_ok && (ctrl.mode != MODE_10BIT) |=> tx_sr[8] == $past(ctrl.tx_ninth_bit_value))
      else $error("ninth bit not loaded on data write");
   chk_tx_start_roll: assert property ( // RQ5
      (tx_state == TX_IDLE) && tx_req && tx_roll |=> (tx_state == TX_START) && !tx_req)
      else $error("transmit did not start on rollover");
   chk_tx_done_set: assert property (tx_finish |=> tx_done_flag && (tx_state == TX_IDLE)) // RQ7
      else $error("done flag not set at end of frame");
   chk_rx_edge_load: assert property ( // RQ8
      (rx_state == RX_HUNT) && rx_fall && ctrl.rx_enable && mode_on
      |=> (rx_sr == RX_SR_INIT) && (rx_div == 4'h0) && (rx_state == RX_BITS))
      else $error("edge did not arm receiver");
   chk_rx_false_start: assert property ( // RQ10
      rx_mid && (rx_state == RX_BITS) && rx_first && rx_bit |=> rx_state == RX_HUNT)
      else $error("false start not rejected");
   chk_rx_reject_keep: assert property ( // RQ12
      rx_final && !rx_done_flag && ctrl.multiproc_enable && !rx_bit |=> !rx_done_flag)
      else $error("rejected frame set done flag");
   chk_rx_accept_store: assert property ( // RQ20
      rx_accept |=> rx_done_flag && (serial_data_buffer == $past(rx_sr[8:1]))
                    && (rx_ninth_bit_flag == $past(rx_bit)))
      else $error("accepted frame not stored");
   chk_rx_tail_hunt: assert property ( // RQ21
      rx_final && (ctrl.mode != MODE_10BIT) |=> (rx_state == RX_TAIL) ##[1:64] (rx_state == RX_HUNT))
      else $error("receiver did not return to hunt");
   chk_rx_mode1_hunt: assert property (rx_final && (ctrl.mode == MODE_10BIT) |=> rx_state == RX_HUNT) // RQ13
      else $error("10-bit receiver did not hunt after final shift");

endmodule

// >>> uam_pkg.sv
// Purpose: Shared constants, types and helpers for the asynchronous serial port.
// Assumes: 8-bit register port, one 20 MHz system clock.
// Notes: Register offsets and control/status layouts live here only.
package uam_pkg;

   // ************************************************************
   // Register map and field positions
   // ************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam int ST_RX_DONE = 0;
   localparam int ST_TX_DONE = 1;
   localparam int ST_RX_NINTH = 2;
   localparam int ST_TX_BUSY = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ************************************************************
   // Modes, counter states and shift patterns
   // ************************************************************
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_10BIT = 2'h1;
   localparam logic [1:0] MODE_11_FIXED = 2'h2;
   localparam logic [1:0] MODE_11_VAR = 2'h3;
   localparam logic [3:0] DIV_LAST = 4'hF;
   localparam logic [3:0] SAMPLE1 = 4'h6;
   localparam logic [3:0] SAMPLE2 = 4'h7;
   localparam logic [3:0] SAMPLE3 = 4'h8;
   localparam logic [8:0] RX_SR_INIT = 9'h1FF;
   localparam logic [7:0] TX_END_PATTERN = 8'h01;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic rate_div32;
      logic tx_clock_select;
      logic rx_clock_select;
      logic tx_ninth_bit_value;
      logic rx_enable;
      logic multiproc_enable;
      logic [1:0] mode;
   } uam_ctrl_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } uam_bus_req_t;

   typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h3} uam_tx_state_t;
   typedef enum logic [1:0] {RX_HUNT = 2'h0, RX_BITS = 2'h1, RX_TAIL = 2'h3} uam_rx_state_t;

   // Right shift with a new bit entering at the top
   function automatic logic [8:0] uam_shift9(input logic [8:0] sr, input logic in_bit);
      uam_shift9 = {in_bit, sr[8:1]};
   endfunction

   function automatic logic uam_vote(input logic a, input logic b, input logic c);
      uam_vote = (a & b) | (a & c) | (b & c);
   endfunction

endpackage

// >>> uam_remote.sv
// Purpose: Remote asynchronous serial peer facing the serial port pins.
// Assumes: Caller gives bit times in sys_clk cycles and calls at a clock edge.
// Notes: Line idles high, as a pulled-up serial line would between frames.
`timescale 1ns/100ps

module uam_remote (
   // Clock
   input wire logic sys_clk,
   // Serial pins, seen from the remote side
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;

   // ************************************************************
   // Frame sender and frame catcher
   // ************************************************************
   // Bits leave LSB first; frame[0] is the start bit
   task automatic send(input logic [10:0] frame, input int nbits, input int bit_cyc);
      @(posedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
         rxd <= frame[i];
         repeat (bit_cyc) @(posedge sys_clk);
      end
      rxd <= 1'b1;
   endtask

   // Start must show within one bit time plus slack, else ok stays low
   task automatic grab(input int nbits, input int bit_cyc, output logic [10:0] frame,
                       output logic ok);
      int n;
      frame = '0;
      n = 0;
      while (txd === 1'b1 && n < bit_cyc + 4) begin
         @(posedge sys_clk);
         n++;
      end
      ok = (txd === 1'b0);
      if (ok) begin
         // Mid-bit sampling tolerates the late start of the catcher
         repeat (bit_cyc / 2) @(posedge sys_clk);
         for (int i = 0; i < nbits; i++) begin
            frame[i] = txd;
            repeat (bit_cyc) @(posedge sys_clk);
         end
      end
   endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the asynchronous serial port.
// Assumes: Timer 1 pulses every 4th cycle, timer 2 every 3rd.
// Notes: Bit times are in sys_clk cycles, 16 ticks to a bit.
`timescale 1ns/100ps

module tb_top;
   import uam_pkg::*;

   logic sys_clk;
   logic sys_rst;
   uam_bus_req_t bus_req;
   logic [7:0] rd_data;
   logic timer1_ovf;
   logic timer2_ovf;
   logic rxd;
   logic txd;
   int tcnt;
   int bad_count;
   int checks_done;

   // ************************************************************
   // Clock, reset and timer pulses
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      bus_req = '0;
      timer1_ovf = 1'b0;
      timer2_ovf = 1'b0;
      tcnt = 0;
      bad_count = 0;
      checks_done = 0;
   end
   always #25 sys_clk = ~sys_clk;
   // Unequal periods, so a swapped rate select misreads the frame
   always @(posedge sys_clk) begin
      tcnt <= tcnt + 1;
      timer1_ovf <= (tcnt % 4 == 0);
      timer2_ovf <= (tcnt % 3 == 0);
   end

   uam_uart dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .rd_data(rd_data), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
      .rxd(rxd), .txd(txd));
   uam_remote remote_u (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

   // ************************************************************
   // Bus cycles, helpers and comparisons
   // ************************************************************
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   // Flags f: {rate_div32, tx_clk_sel, rx_clk_sel, tx_ninth, multiproc}
   function automatic uam_ctrl_t mk(input logic [1:0] m, input logic [4:0] f);
      uam_ctrl_t c;
      c = '0;
      c.mode = m;
      c.rx_enable = 1'b1;
      c.multiproc_enable = f[0];
      c.tx_ninth_bit_value = f[1];
      c.rx_clock_select = f[2];
      c.tx_clock_select = f[3];
      c.rate_div32 = f[4];
      return c;
   endfunction

   function automatic logic [7:0] stat(input logic rx, input logic tx, input logic n9,
                                       input logic busy);
      logic [7:0] s;
      s = 8'h00;
      s[ST_RX_DONE] = rx;
      s[ST_TX_DONE] = tx;
      s[ST_RX_NINTH] = n9;
      s[ST_TX_BUSY] = busy;
      return s;
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk11(input logic [10:0] got, input logic [10:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic reset_case();
      logic [7:0] v;
      chk8({7'h00, txd}, 8'h01);
      chk8(rd_data, 8'h00);
      bus_rd(REG_STATUS, v);
      chk8(v, 8'h00);
      bus_rd(REG_CTRL, v);
      chk8(v, CTRL_RESET);
      // Mode 0 keeps both directions idle, so a data write starts nothing
      bus_wr(REG_DATA, 8'h55);
      bus_rd(REG_STATUS, v);
      chk8(v, 8'h00);
      chk8({7'h00, txd}, 8'h01);
      bus_wr(REG_CTRL, 8'h49);
      bus_wr(4'hF, 8'hFF);
      bus_rd(4'hF, v);
      chk8(v, 8'h00);
      bus_rd(REG_CTRL, v);
      chk8(v, 8'h49);
   endtask

   task automatic tx_case(input uam_ctrl_t c, input logic [7:0] d, input int nb, input int bc);
      logic [10:0] got;
      logic ok;
      logic [7:0] s;
      bus_wr(REG_CTRL, c);
      bus_wr(REG_DATA, d);
      bus_rd(REG_STATUS, s);
      chk8(s, stat(1'b0, 1'b0, 1'b0, 1'b1));
      // Write while busy must be dropped, else the frame below carries it
      bus_wr(REG_DATA, ~d);
      remote_u.grab(nb, bc, got, ok);
      chk8({7'h00, ok}, 8'h01);
      chk11(got, (nb == 10) ? {2'b01, d, 1'b0} : {1'b1, c.tx_ninth_bit_value, d, 1'b0});
      repeat (bc) @(posedge sys_clk);
      bus_rd(REG_STATUS, s);
      chk8(s, stat(1'b0, 1'b1, 1'b0, 1'b0));
      bus_wr(REG_STATUS, 8'h03);
   endtask

   task automatic rx_case(input uam_ctrl_t c, input logic [10:0] f, input int nb, input int bc,
                          input logic [7:0] ed, input logic [7:0] es);
      logic [7:0] v;
      bus_wr(REG_CTRL, c);
      remote_u.send(f, nb, bc);
      repeat (bc) @(posedge sys_clk);
      bus_rd(REG_STATUS, v);
      chk8(v, es);
      bus_rd(REG_DATA, v);
      chk8(v, ed);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reset_case();
      tx_case(mk(MODE_10BIT, 5'h00), 8'hA5, 10, 64);
      tx_case(mk(MODE_10BIT, 5'h08), 8'h0F, 10, 48);
      tx_case(mk(MODE_11_FIXED, 5'h00), 8'h5A, 11, 16);
      tx_case(mk(MODE_11_FIXED, 5'h12), 8'h81, 11, 32);
      tx_case(mk(MODE_11_VAR, 5'h0A), 8'h3E, 11, 48);
      rx_case(mk(MODE_10BIT, 5'h04), {2'b01, 8'h3C, 1'b0}, 10, 48, 8'h3C,
              stat(1'b1, 1'b0, 1'b1, 1'b0));
      rx_case(mk(MODE_10BIT, 5'h04), {2'b01, 8'hC3, 1'b0}, 10, 48, 8'h3C,
              stat(1'b1, 1'b0, 1'b1, 1'b0));
      bus_wr(REG_STATUS, 8'h03);
      // Ninth-bit flag keeps the stop bit of the last accepted frame
      rx_case(mk(MODE_10BIT, 5'h01), {2'b00, 8'h5A, 1'b0}, 10, 64, 8'h3C,
              stat(1'b0, 1'b0, 1'b1, 1'b0));
      rx_case(mk(MODE_10BIT, 5'h00), {2'b00, 8'h96, 1'b0}, 10, 64, 8'h96,
              stat(1'b1, 1'b0, 1'b0, 1'b0));
      bus_wr(REG_STATUS, 8'h03);
      bus_wr(REG_CTRL, mk(MODE_11_FIXED, 5'h00));
      // Low for a quarter bit: votes at the middle must see high
      remote_u.send(11'h000, 1, 4);
      repeat (40) @(posedge sys_clk);
      rx_case(mk(MODE_11_FIXED, 5'h00), {2'b10, 8'hE1, 1'b0}, 11, 16, 8'hE1,
              stat(1'b1, 1'b0, 1'b0, 1'b0));
      bus_wr(REG_STATUS, 8'h03);
      rx_case(mk(MODE_11_VAR, 5'h05), {2'b10, 8'h11, 1'b0}, 11, 48, 8'hE1,
              stat(1'b0, 1'b0, 1'b0, 1'b0));
      rx_case(mk(MODE_11_VAR, 5'h05), {2'b01, 8'h22, 1'b0}, 11, 48, 8'h22,
              stat(1'b1, 1'b0, 1'b1, 1'b0));
      conclude();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      conclude();
   end
endmodule
